// ==== inc/dl_pkg.sv ====
// package: constants, register map, descriptor layout and types of the download engine
package dl_pkg;
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned POLL_UNIT_NS = 320;
    localparam int unsigned POLL_UNIT_CYCLES = (POLL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] REG_LIST_PTR = 12'h000;
    localparam logic [APB_AW-1:0] REG_POLL_RATE = 12'h004;
    localparam logic [APB_AW-1:0] REG_COMMAND = 12'h008;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h00C;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam int CMD_STALL_BIT = 0;
    localparam int CMD_RESUME_BIT = 1;
    localparam int ST_DONE_BIT = 1;

    // descriptor layout, byte offsets from the descriptor base
    localparam logic [31:0] OFS_NEXT = 32'h0000_0000;
    localparam logic [31:0] OFS_HEADER = 32'h0000_0004;
    localparam logic [31:0] OFS_FRAG0 = 32'h0000_0008;
    localparam logic [31:0] FRAG_PAIR_BYTES = 32'h0000_0008;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    localparam int HDR_DONE_BIT = 16;
    localparam int HDR_EMPTY_BIT = 29;
    localparam int HDR_NOTIFY_BIT = 31;
    localparam logic [31:0] HDR_DONE_MASK = 32'h0001_0000;
    localparam int LEN_LAST_BIT = 31;
    localparam int LEN_W = 13;
    localparam int WORDS_W = 12;
    localparam logic [LEN_W:0] LEN_ROUND = 14'h0003;

    // access control byte sits in the low byte of the first data word
    localparam int AC_PRI_LSB = 5;
    localparam int PRI_W = 3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_HDR_RD = 4'h1,
        ST_HDR_PUSH = 4'h2,
        ST_FRAG_ADDR = 4'h3,
        ST_FRAG_LEN = 4'h4,
        ST_SPACE = 4'h5,
        ST_DATA = 4'h6,
        ST_DONE_WR = 4'h7,
        ST_HDR_RD2 = 4'h8,
        ST_NEXT_RD = 4'h9,
        ST_POLL_WAIT = 4'hA,
        ST_STALLED = 4'hB
    } state_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic busy;
        logic stalled;
        logic done;
        logic pending;
    } status_t;
endpackage

// ==== src/dl_engine.sv ====
// transmit download engine: descriptor walk, stall and resume, polling, apb registers
// What this block does
// - download packets in linked descriptor order
// - stall accepted anytime, halts at packet boundary
// - stalled list pointer names the stall descriptor
// - list pointer write ignored unless it reads zero
// - command pending holds until stall takes effect
// - zero poll rate disables polling, nonzero enables
// - transmit only with token priority not above frame
// - access priority rewritten with token priority
// - start needs nonzero pointer and no stall
// - fetch header; empty skips, else push header
// - check fifo room before each burst
// - fetch fragment address, length, then move data
// - set done flag in header after last fragment
// - after stall, wait for resume command
// - refetch header; notify bit raises done status
// - zero link idles; polling rereads link
// - list pointer read forces an immediate poll
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module dl_engine #(
    parameter int MAX_BURST = 8,
    parameter int FREE_W = 8,
    parameter int POLL_W = 8
) (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [dl_pkg::APB_AW-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output var dl_pkg::mem_req_t O_MEM,
    input wire logic I_MEM_ACK,
    input wire logic [31:0] I_MEM_RDATA,
    output logic O_FIFO_VALID,
    output logic [31:0] O_FIFO_DATA,
    input wire logic [FREE_W-1:0] I_FIFO_FREE,
    input wire logic I_TOKEN_VALID,
    input wire logic [dl_pkg::PRI_W-1:0] I_TOKEN_PRI,
    output logic O_TX_GRANT
);
    import dl_pkg::*;

    state_t state;
    state_t next_state;
    logic [31:0] list_ptr;
    logic [31:0] header;
    logic [31:0] frag_addr;
    logic [31:0] frag_ofs;
    logic [31:0] poll_cnt;
    logic [31:0] prdata;
    logic [31:0] fifo_data;
    logic [POLL_W-1:0] poll_rate;
    logic [WORDS_W-1:0] frag_words;
    logic [WORDS_W-1:0] burst_left;
    logic [PRI_W-1:0] held_pri;
    logic stall_active;
    logic cmd_pending;
    logic done_status;
    logic frag_last;
    logic poll_kick;
    logic first_data;
    logic fifo_valid;
    logic tx_grant;
    logic gate_allow;
    logic [31:0] gate_word;

    // apb decode
    wire logic apb_setup = I_PSEL & ~I_PENABLE;
    wire logic apb_access = I_PSEL & I_PENABLE;
    wire logic apb_wr = apb_access & I_PWRITE;
    wire logic apb_rd = apb_access & ~I_PWRITE;
    wire logic hit_list = I_PADDR == REG_LIST_PTR;
    wire logic hit_poll = I_PADDR == REG_POLL_RATE;
    wire logic hit_cmd = I_PADDR == REG_COMMAND;
    wire logic hit_status = I_PADDR == REG_STATUS;
    wire logic hit_any = hit_list | hit_poll | hit_cmd | hit_status;
    wire logic list_wr = apb_wr & hit_list;
    wire logic list_rd = apb_rd & hit_list;
    wire logic stall_wr = apb_wr & hit_cmd & I_PWDATA[CMD_STALL_BIT];
    wire logic resume_wr = apb_wr & hit_cmd & I_PWDATA[CMD_RESUME_BIT];
    wire logic done_clr = apb_wr & hit_status & I_PWDATA[ST_DONE_BIT];

    // engine status
    wire logic list_zero = list_ptr == WORD_ZERO;
    wire logic poll_on = poll_rate != '0;
    wire logic at_boundary = (state == ST_IDLE) | (state == ST_STALLED);
    wire logic link_zero = I_MEM_RDATA == WORD_ZERO;
    wire status_t status = '{
        busy: state != ST_IDLE,
        stalled: state == ST_STALLED,
        done: done_status,
        pending: cmd_pending
    };

    // memory handshake
    wire logic mem_rd_state = (state == ST_HDR_RD) | (state == ST_HDR_RD2) | (state == ST_FRAG_ADDR)
        | (state == ST_FRAG_LEN) | (state == ST_DATA) | (state == ST_NEXT_RD);
    wire logic mem_wr_state = state == ST_DONE_WR;
    wire logic mem_ack = (mem_rd_state | mem_wr_state) & I_MEM_ACK;
    wire logic [31:0] frag_entry = list_ptr + frag_ofs;
    wire logic [31:0] mem_addr = (state == ST_DATA) ? frag_addr
        : (state == ST_FRAG_ADDR) ? frag_entry
        : (state == ST_FRAG_LEN) ? frag_entry + WORD_BYTES
        : (state == ST_NEXT_RD) ? list_ptr + OFS_NEXT
        : list_ptr + OFS_HEADER;

    // fragment length in bytes rounds up to whole words
    wire logic [LEN_W:0] len_round = {1'h0, I_MEM_RDATA[LEN_W-1:0]} + LEN_ROUND;
    wire logic [WORDS_W-1:0] len_words = len_round[LEN_W:2];
    wire logic [WORDS_W-1:0] max_burst = WORDS_W'(MAX_BURST);
    wire logic [WORDS_W-1:0] burst_need = (frag_words > max_burst) ? max_burst : frag_words;
    // a word still in the output register has not reached the fifo count yet
    wire logic [WORDS_W:0] need_slots = {1'h0, burst_need} + {{WORDS_W{1'h0}}, fifo_valid};
    wire logic [WORDS_W:0] free_slots = (WORDS_W + 1)'(I_FIFO_FREE);
    wire logic burst_room = free_slots >= need_slots;
    wire logic hdr_room = free_slots > {{WORDS_W{1'h0}}, fifo_valid};
    wire logic frag_end_next = frag_last ? 1'h1 : 1'h0;

    // fifo pushes
    wire logic push_hdr = (state == ST_HDR_PUSH) & hdr_room;
    wire logic push_data = (state == ST_DATA) & mem_ack;
    wire logic burst_end = push_data & (burst_left == WORDS_W'(1));
    wire logic frag_end = burst_end & (frag_words == WORDS_W'(1));

    // polling timer, restarted on every entry to the wait
    wire logic [31:0] poll_span = 32'(poll_rate) * POLL_UNIT_CYCLES;
    wire logic poll_fire = poll_kick | (poll_cnt >= poll_span) | ~poll_on;

    assign O_MEM = '{
        req: mem_rd_state | mem_wr_state,
        we: mem_wr_state,
        addr: mem_addr,
        wdata: header | HDR_DONE_MASK
    };
    assign O_PRDATA = prdata;
    assign O_PREADY = 1'h1;
    assign O_PSLVERR = apb_access & ~hit_any;
    assign O_FIFO_VALID = fifo_valid;
    assign O_FIFO_DATA = fifo_data;
    assign O_TX_GRANT = tx_grant;

    dl_pri_gate u_pri_gate (
        .i_word(I_MEM_RDATA),
        .i_first(first_data),
        .i_frame_pri(first_data ? I_MEM_RDATA[AC_PRI_LSB +: PRI_W] : held_pri),
        .i_token_valid(I_TOKEN_VALID),
        .i_token_pri(I_TOKEN_PRI),
        .o_allowed(gate_allow),
        .o_word(gate_word)
    );

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (!list_zero && !stall_active) begin
                    next_state = ST_HDR_RD;
                end
            end
            ST_HDR_RD: begin
                if (mem_ack) begin
                    next_state = I_MEM_RDATA[HDR_EMPTY_BIT] ? ST_NEXT_RD : ST_HDR_PUSH;
                end
            end
            ST_HDR_PUSH: begin
                if (hdr_room) begin
                    next_state = ST_FRAG_ADDR;
                end
            end
            ST_FRAG_ADDR: begin
                if (mem_ack) begin
                    next_state = ST_FRAG_LEN;
                end
            end
            ST_FRAG_LEN: begin
                if (mem_ack) begin
                    if (len_words != '0) begin
                        next_state = ST_SPACE;
                    end else begin
                        next_state = I_MEM_RDATA[LEN_LAST_BIT] ? ST_DONE_WR : ST_FRAG_ADDR;
                    end
                end
            end
            ST_SPACE: begin
                if (burst_room) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (frag_end) begin
                    next_state = frag_end_next ? ST_DONE_WR : ST_FRAG_ADDR;
                end else if (burst_end) begin
                    next_state = ST_SPACE;
                end
            end
            ST_DONE_WR: begin
                if (mem_ack) begin
                    next_state = ST_HDR_RD2;
                end
            end
            ST_HDR_RD2: begin
                if (mem_ack) begin
                    next_state = ST_NEXT_RD;
                end
            end
            ST_NEXT_RD: begin
                if (mem_ack) begin
                    if (stall_active) begin
                        next_state = ST_STALLED;
                    end else if (!link_zero) begin
                        next_state = ST_HDR_RD;
                    end else begin
                        next_state = poll_on ? ST_POLL_WAIT : ST_IDLE;
                    end
                end
            end
            ST_POLL_WAIT: begin
                if (stall_active) begin
                    next_state = ST_STALLED;
                end else if (poll_fire) begin
                    next_state = ST_NEXT_RD;
                end
            end
            ST_STALLED: begin
                if (!stall_active) begin
                    next_state = ST_NEXT_RD;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // hardware loads only while the pointer is nonzero, so it never meets a software write
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            list_ptr <= WORD_ZERO;
        end else if ((state == ST_NEXT_RD) && mem_ack && !stall_active) begin
            list_ptr <= !link_zero ? I_MEM_RDATA : (poll_on ? list_ptr : WORD_ZERO);
        end else if (list_wr && list_zero) begin
            list_ptr <= I_PWDATA;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            poll_rate <= '0;
            stall_active <= 1'h0;
        end else begin
            if (apb_wr && hit_poll) begin
                poll_rate <= I_PWDATA[POLL_W-1:0];
            end
            if (stall_wr) begin
                stall_active <= 1'h1;
            end else if (resume_wr) begin
                stall_active <= 1'h0;
            end
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            cmd_pending <= 1'h0;
            done_status <= 1'h0;
        end else begin
            if (stall_wr) begin
                cmd_pending <= 1'h1;
            end else if (at_boundary && stall_active) begin
                cmd_pending <= 1'h0;
            end
            if ((state == ST_HDR_RD2) && mem_ack && I_MEM_RDATA[HDR_NOTIFY_BIT]) begin
                done_status <= 1'h1;
            end else if (done_clr) begin
                done_status <= 1'h0;
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            poll_cnt <= WORD_ZERO;
            poll_kick <= 1'h0;
        end else begin
            poll_cnt <= (state == ST_POLL_WAIT) ? poll_cnt + 32'h0000_0001 : WORD_ZERO;
            if (list_rd) begin
                poll_kick <= 1'h1;
            end else if (state == ST_NEXT_RD) begin
                poll_kick <= 1'h0;
            end
        end
    end

    // descriptor walk registers
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            header <= WORD_ZERO;
            frag_ofs <= OFS_FRAG0;
            frag_addr <= WORD_ZERO;
            frag_words <= '0;
            frag_last <= 1'h0;
            burst_left <= '0;
        end else begin
            if ((state == ST_HDR_RD) && mem_ack) begin
                header <= I_MEM_RDATA;
                frag_ofs <= OFS_FRAG0;
            end
            if ((state == ST_FRAG_ADDR) && mem_ack) begin
                frag_addr <= I_MEM_RDATA;
            end
            if ((state == ST_FRAG_LEN) && mem_ack) begin
                frag_words <= len_words;
                frag_last <= I_MEM_RDATA[LEN_LAST_BIT];
                frag_ofs <= frag_ofs + FRAG_PAIR_BYTES;
            end
            if ((state == ST_SPACE) && burst_room) begin
                burst_left <= burst_need;
            end
            if (push_data) begin
                frag_addr <= frag_addr + WORD_BYTES;
                frag_words <= frag_words - WORDS_W'(1);
                burst_left <= burst_left - WORDS_W'(1);
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            fifo_valid <= 1'h0;
            fifo_data <= WORD_ZERO;
            first_data <= 1'h0;
            held_pri <= '0;
            tx_grant <= 1'h0;
        end else begin
            fifo_valid <= push_hdr | push_data;
            if (push_hdr) begin
                fifo_data <= header;
            end else if (push_data) begin
                fifo_data <= gate_word;
            end
            if ((state == ST_HDR_RD) && mem_ack) begin
                first_data <= 1'h1;
            end else if (push_data) begin
                first_data <= 1'h0;
            end
            if (push_data && first_data) begin
                held_pri <= I_MEM_RDATA[AC_PRI_LSB +: PRI_W];
            end
            tx_grant <= gate_allow;
        end
    end

    // read data is latched in setup so the access phase answers with zero wait
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            prdata <= WORD_ZERO;
        end else if (apb_setup) begin
            prdata <= hit_list ? list_ptr
                : hit_poll ? 32'(poll_rate)
                : hit_status ? 32'(status)
                : WORD_ZERO;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    a_list_write_ignored: assert property (list_wr && !list_zero && !((state == ST_NEXT_RD) && mem_ack)
        |=> list_ptr == $past(list_ptr)) else $error("list pointer took a write while nonzero");
    a_list_write_taken: assert property (list_wr && list_zero |=> list_ptr == $past(I_PWDATA))
        else $error("list pointer write lost while zero");
    a_start_guard: assert property ((state == ST_HDR_RD) && ($past(state) == ST_IDLE)
        |-> $past(list_ptr) != WORD_ZERO && !$past(stall_active)) else $error("started without pointer");
    a_pending_holds: assert property (cmd_pending && !at_boundary |=> cmd_pending)
        else $error("command pending cleared early");
    a_pending_clears: assert property (cmd_pending && (state == ST_IDLE) && !stall_wr
        ##1 !stall_wr |-> ##[0:1] !cmd_pending) else $error("command pending stuck");
    a_stall_point: assert property ((state == ST_NEXT_RD) && mem_ack && stall_active
        |=> (state == ST_STALLED) && list_ptr == $past(list_ptr)) else $error("stall point lost");
    a_stall_waits: assert property ((state == ST_STALLED) && stall_active |=> state == ST_STALLED)
        else $error("left stall without resume");
    a_resume_link: assert property ((state == ST_STALLED) && !stall_active
        |=> (state == ST_NEXT_RD) && O_MEM.addr == list_ptr + OFS_NEXT) else $error("resume skipped link");
    a_empty_skip: assert property ((state == ST_HDR_RD) && mem_ack && I_MEM_RDATA[HDR_EMPTY_BIT]
        |=> state == ST_NEXT_RD ##1 !O_FIFO_VALID) else $error("empty descriptor pushed");
    a_done_write: assert property ((state == ST_DONE_WR) |-> O_MEM.we && O_MEM.wdata[HDR_DONE_BIT]
        && O_MEM.addr == list_ptr + OFS_HEADER) else $error("done flag write wrong");
    a_burst_room: assert property ((state == ST_SPACE) ##1 (state == ST_DATA)
        |-> $past(free_slots) >= $past(need_slots)) else $error("burst without room");
    a_notify_flag: assert property ((state == ST_HDR_RD2) && mem_ack && I_MEM_RDATA[HDR_NOTIFY_BIT]
        |=> done_status && state == ST_NEXT_RD) else $error("notify not raised");
    a_link_follow: assert property ((state == ST_NEXT_RD) && mem_ack && !stall_active && !link_zero
        |=> list_ptr == $past(I_MEM_RDATA) && state == ST_HDR_RD) else $error("link not followed");
    a_end_no_poll: assert property ((state == ST_NEXT_RD) && mem_ack && !stall_active && link_zero
        && !poll_on |=> state == ST_IDLE && list_zero) else $error("end of list not idled");
    a_kick_poll: assert property ((state == ST_POLL_WAIT) && poll_kick && !stall_active
        |=> state == ST_NEXT_RD) else $error("poll kick ignored");
    a_ac_rewrite: assert property (push_data && first_data && gate_allow
        |=> O_FIFO_DATA[AC_PRI_LSB +: PRI_W] == $past(I_TOKEN_PRI)) else $error("priority not rewritten");
endmodule
`default_nettype wire

// ==== src/dl_pri_gate.sv ====
// token priority check and access priority rewrite of the first frame word
`timescale 1ns/100ps
`default_nettype none
module dl_pri_gate (
    input wire logic [31:0] i_word,
    input wire logic i_first,
    input wire logic [dl_pkg::PRI_W-1:0] i_frame_pri,
    input wire logic i_token_valid,
    input wire logic [dl_pkg::PRI_W-1:0] i_token_pri,
    output logic o_allowed,
    output logic [31:0] o_word
);
    import dl_pkg::*;

    wire logic [31:0] pri_mask = {{(32 - PRI_W){1'h0}}, {PRI_W{1'h1}}} << AC_PRI_LSB;
    wire logic [31:0] pri_new = {{(32 - PRI_W){1'h0}}, i_token_pri} << AC_PRI_LSB;

    // a token may carry the frame only if its priority does not exceed the frame's
    assign o_allowed = i_token_valid & (i_token_pri <= i_frame_pri);
    // frame-control priority is never touched, so the original priority survives
    assign o_word = (i_first & o_allowed) ? ((i_word & ~pri_mask) | pri_new) : i_word;
endmodule
`default_nettype wire

// ==== testbench/host_mem.sv ====
// host memory model answering the engine's word requests
`timescale 1ns/100ps
`default_nettype none
module host_mem (
    input wire logic i_clk,
    input wire logic i_go,
    input wire dl_pkg::mem_req_t i_mem,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    import dl_pkg::*;
    logic [31:0] mem [0:1023];
    logic [31:0] last = 32'h0;
    // i_go low models a slow host: the request must wait
    assign o_ack = i_mem.req & i_go;
    // between answers the data lines show a flipped copy, so stale data never looks valid
    assign o_rdata = o_ack ? mem[i_mem.addr[11:2]] : ~last;
    always @(posedge i_clk) begin
        if (o_ack) begin
            last <= o_rdata;
            if (i_mem.we)
                mem[i_mem.addr[11:2]] <= i_mem.wdata;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the download engine
`timescale 1ns/100ps
`default_nettype none
module tb;
    import dl_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, hold = 0, tv = 1, prdy, perr, ack, fv, grant, e;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rdat, fd, r;
    logic [7:0] free = 8'h00;
    logic [2:0] tp = 3'h3;
    mem_req_t mreq;
    integer seed = 32'he1f3aaad, fail_count = 0, n_tests = 0;
    logic [31:0] got[$], exp[$];
    dl_engine dut (.I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr),
        .O_MEM(mreq), .I_MEM_ACK(ack), .I_MEM_RDATA(rdat), .O_FIFO_VALID(fv), .O_FIFO_DATA(fd),
        .I_FIFO_FREE(free), .I_TOKEN_VALID(tv), .I_TOKEN_PRI(tp), .O_TX_GRANT(grant));
    host_mem m (.i_clk(clk), .i_go(go), .i_mem(mreq), .o_ack(ack), .o_rdata(rdat));
    initial forever #25 clk = ~clk;
    always @(posedge clk) begin
        go <= !hold && (($random(seed) & 3) != 0);
        free <= 8'($random(seed));
        if (fv === 1'b1)
            got.push_back(fd);
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        r = prd;
        e = perr;
        psel <= 0;
        pen <= 0;
    endtask
    // one-fragment descriptor of one word; priority 5 sits in the access and frame control bytes
    task automatic dsc(input logic [31:0] b, input logic [31:0] nx, input logic [31:0] fl);
        logic [31:0] h, d;
        h = ($random(seed) & 32'h0000_FFFF) | fl;
        d = ($random(seed) & 32'hFFFF_F81F) | 32'h0000_05A0;
        m.mem[b[11:2]] = nx;
        m.mem[b[11:2] + 1] = h;
        m.mem[b[11:2] + 2] = b + 32'h0000_0800;
        m.mem[b[11:2] + 3] = 32'h8000_0004;
        m.mem[b[11:2] + 512] = d;
        if (!fl[HDR_EMPTY_BIT]) begin
            exp.push_back(h);
            exp.push_back(tp <= 3'h5 ? (d & ~(32'h7 << AC_PRI_LSB)) | (32'(tp) << AC_PRI_LSB) : d);
        end
    endtask
    task automatic settle(input int n);
        for (int i = 0; i < 3000 && got.size() < n; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        chk(32'(got.size()), 32'(exp.size()));
        foreach (exp[i]) chk(got[i], exp[i]);
        got.delete();
        exp.delete();
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #(50 * 20000);
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        for (int a = 0; a < 16; a += 4) begin
            apb(0, 12'(a), 32'h0);
            chk(r, 32'h0);
        end
        apb(0, 12'h010, 32'h0);
        chk(32'(e), 32'h1);
        dsc(32'h100, 32'h200, 32'h8000_0000);
        dsc(32'h200, 32'h0, 32'h0);
        apb(1, REG_LIST_PTR, 32'h100);
        settle(4);
        chk(32'(grant), 32'h1);
        // a token above the frame priority must neither grant nor rewrite
        tp <= 3'h7;
        repeat (3) @(posedge clk);
        chk(32'(grant), 32'h0);
        chk(m.mem[32'h104 >> 2] & HDR_DONE_MASK, HDR_DONE_MASK);
        apb(0, REG_STATUS, 32'h0);
        chk(32'(r[ST_DONE_BIT]), 32'h1);
        apb(0, REG_LIST_PTR, 32'h0);
        chk(r, 32'h0);
        apb(1, REG_STATUS, 32'h2);
        apb(0, REG_STATUS, 32'h0);
        chk(32'(r[ST_DONE_BIT]), 32'h0);
        // stall lands mid packet; a second pointer write must be dropped
        dsc(32'h100, 32'h300, 32'h0);
        dsc(32'h300, 32'h0, 32'h2000_0000);
        apb(1, REG_LIST_PTR, 32'h100);
        apb(1, REG_LIST_PTR, 32'h300);
        apb(1, REG_COMMAND, 32'h1);
        repeat (200) @(posedge clk);
        chk(32'(got.size()), 32'h2);
        apb(0, REG_STATUS, 32'h0);
        chk(32'(r[0]), 32'h0);
        chk(32'(r[2]), 32'h1);
        apb(0, REG_LIST_PTR, 32'h0);
        chk(r, 32'h100);
        dsc(32'h200, 32'h300, 32'h0);
        m.mem[32'h100 >> 2] = 32'h200;
        apb(1, REG_COMMAND, 32'h2);
        settle(4);
        apb(1, REG_POLL_RATE, 32'h1);
        dsc(32'h300, 32'h0, 32'h2000_0000);
        apb(1, REG_LIST_PTR, 32'h300);
        repeat (100) @(posedge clk);
        chk(32'(got.size()), 32'h0);
        dsc(32'h400, 32'h0, 32'h0);
        m.mem[32'h300 >> 2] = 32'h400;
        settle(2);
        apb(0, REG_LIST_PTR, 32'h0);
        chk(r, 32'h400);
        // polling insert made in zero time; hold rises and falls before any clock edge, so hold never lowers go
        hold = 1;
        dsc(32'h500, 32'h0, 32'h0);
        m.mem[32'h400 >> 2] = 32'h500;
        dsc(32'h600, 32'h0, 32'h0);
        m.mem[32'h500 >> 2] = WORD_ZERO;
        chk(m.mem[32'h504 >> 2] & HDR_DONE_MASK, 32'h0);
        m.mem[32'h500 >> 2] = 32'h600;
        hold = 0;
        settle(4);
        apb(1, REG_POLL_RATE, 32'h0);
        repeat (40) @(posedge clk);
        apb(0, REG_LIST_PTR, 32'h0);
        chk(r, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
